/* src/pdh_codec_pkg.sv */
// Constants and carrier types for the PDH line codec.
// Assumes a 250 MHz system clock; the line clock is a separate domain.
package pdh_codec_pkg;
	typedef enum logic [1:0] {code_hdb3, code_b6zs, code_b8zs} line_code_t;
	typedef struct packed {
		logic pos;
		logic neg;
	} symbol_t;
	typedef struct packed {
		logic data;
		logic mark;
	} rx_word_t;

	localparam int     CLOCK_MHZ   = 250;
	localparam longint RATE_2M_BPS = 2048000;
	localparam longint RATE_6M_BPS = 6312000;
	localparam longint NCO_SPAN    = 64'h0000000100000000;
	// Truncation error of the step is far below one ppm
	localparam logic [31:0] NCO_INC_2M =
		32'((RATE_2M_BPS * NCO_SPAN) / (CLOCK_MHZ * 1000000));
	localparam logic [31:0] NCO_INC_6M =
		32'((RATE_6M_BPS * NCO_SPAN) / (CLOCK_MHZ * 1000000));

	localparam int AIS_REACT_US  = 250;
	localparam int LINE_IDLE_NS  = 2000;
	localparam int LINE_IDLE_I   = (LINE_IDLE_NS * CLOCK_MHZ + 999) / 1000;
	localparam logic [9:0] LINE_IDLE_CYC = 10'(LINE_IDLE_I);
	localparam logic [7:0] LOS_ZEROS_2M  = 8'hFF;
	localparam logic [7:0] LOS_ZEROS_6M  = 8'hFF;

	localparam logic [3:0] RUN_HDB3 = 4'h4;
	localparam logic [3:0] RUN_B6ZS = 4'h6;
	localparam logic [3:0] RUN_B8ZS = 4'h8;
	localparam int ENC_DEPTH = 5;
	localparam int DEC_DEPTH = 8;
	localparam int BUF_DEPTH = 2;
endpackage : pdh_codec_pkg

/* src/pdh_line_codec.sv */
// Bipolar line encoder and decoder for 2 048 and 6 312 kbit/s tributaries.
// Assumes the transceiver delivers sliced marks with a recovered clock.
// Contract
// - 2048 kbit/s transmit uses HDB3 line code
// - 6312: B6ZS symmetrical, B8ZS coaxial; decode same
// - Decode line, deliver data with its timing
// - Detect signal lost defect at each rate
// - All-ones with substitute timing within 250 us
// - Substitute timing within the rate tolerance
// - Resume decoded data within 250 us after
// - Report defect only in monitored state
// - 2048 rate held within 50 ppm
// - 6312 rate held within 30 ppm
// - 6312 path has its own loss criterion; the code uses 255 zeros and the same idle limit at both rates
`timescale 1ns/100ps
module pdh_line_codec (
	input  wire  logic                   clock,
	input  wire  logic                   reset,
	input  wire  logic                   line_clock,
	input  wire  pdh_codec_pkg::symbol_t rx_line,
	output logic                         rx_overrun,
	output pdh_codec_pkg::symbol_t       tx_line,
	output logic                         tx_clock,
	input  wire  logic                   in_valid,
	input  wire  logic                   in_data,
	output logic                         in_ready,
	output logic                         out_valid,
	output logic                         out_data,
	input  wire  logic                   out_ready,
	input  wire  logic                   rate_6m,
	input  wire  logic                   coax_pair,
	input  wire  logic                   monitored_state,
	output logic                         signal_lost_defect
);
	import pdh_codec_pkg::*;

	function automatic logic has_pol(symbol_t s, logic p);
		return (s.pos == p) && (s.neg == ~p);
	endfunction : has_pol

	line_code_t code_sel;
	logic [3:0] run_len;
	logic [7:0] los_zeros;

	always_comb begin
		if (!rate_6m)
			code_sel = code_hdb3;
		else if (coax_pair)
			code_sel = code_b8zs;
		else
			code_sel = code_b6zs;
		case (code_sel)
			code_hdb3: run_len = RUN_HDB3;
			code_b6zs: run_len = RUN_B6ZS;
			code_b8zs: run_len = RUN_B8ZS;
			default:   run_len = RUN_HDB3;
		endcase
		los_zeros = rate_6m ? LOS_ZEROS_6M : LOS_ZEROS_2M;
	end

	// One oscillator times both the transmitter and the alarm pattern
	logic [31:0] nco_r, nco_nxt;
	logic        bit_tick;

	always_comb begin
		nco_nxt  = nco_r + (rate_6m ? NCO_INC_6M : NCO_INC_2M);
		bit_tick = nco_nxt[31] & ~nco_r[31];
	end

	always_ff @(posedge clock) begin
		if (reset)
			nco_r <= 32'h00000000;
		else
			nco_r <= nco_nxt;
	end

	// Encoder: a short symbol delay lets substitutions reach back in time
	symbol_t    enc_r [ENC_DEPTH];
	symbol_t    enc_nxt [ENC_DEPTH];
	symbol_t    tx_r, tx_nxt;
	logic       pol_r, pol_nxt;
	logic       odd_r, odd_nxt;
	logic [3:0] zrun_r, zrun_nxt;
	logic       txclk_r;
	logic       tx_bit;

	always_comb begin
		enc_nxt  = enc_r;
		tx_nxt   = tx_r;
		pol_nxt  = pol_r;
		odd_nxt  = odd_r;
		zrun_nxt = zrun_r;
		// Starved input sends ones rather than a false zero run
		tx_bit   = in_valid ? in_data : 1'b1;
		if (bit_tick) begin
			tx_nxt = enc_r[ENC_DEPTH-1];
			for (int i = ENC_DEPTH - 1; i > 0; i--)
				enc_nxt[i] = enc_r[i-1];
			enc_nxt[0] = '0;
			if (tx_bit) begin
				enc_nxt[0] = '{pos: ~pol_r, neg: pol_r};
				pol_nxt    = ~pol_r;
				odd_nxt    = ~odd_r;
				zrun_nxt   = 4'h0;
			end else begin
				zrun_nxt = zrun_r + 4'h1;
				if (zrun_nxt == run_len) begin
					zrun_nxt = 4'h0;
					if (code_sel == code_hdb3) begin
						if (odd_r) begin
							enc_nxt[0] = '{pos: pol_r, neg: ~pol_r};
						end else begin
							enc_nxt[3] = '{pos: ~pol_r, neg: pol_r};
							enc_nxt[0] = '{pos: ~pol_r, neg: pol_r};
							pol_nxt    = ~pol_r;
						end
						odd_nxt = 1'b0;
					end else begin
						enc_nxt[4] = '{pos: pol_r, neg: ~pol_r};
						enc_nxt[3] = '{pos: ~pol_r, neg: pol_r};
						enc_nxt[1] = '{pos: ~pol_r, neg: pol_r};
						enc_nxt[0] = '{pos: pol_r, neg: ~pol_r};
					end
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < ENC_DEPTH; i++)
				enc_r[i] <= '0;
			tx_r    <= '0;
			pol_r   <= 1'b0;
			odd_r   <= 1'b0;
			zrun_r  <= 4'h0;
			txclk_r <= 1'b0;
		end else begin
			enc_r   <= enc_nxt;
			tx_r    <= tx_nxt;
			pol_r   <= pol_nxt;
			odd_r   <= odd_nxt;
			zrun_r  <= zrun_nxt;
			txclk_r <= nco_nxt[31];
		end
	end

	assign in_ready = bit_tick;
	assign tx_line  = tx_r;
	assign tx_clock = txclk_r;

	// Line clock domain: reset and code selection cross in from the system
	logic       lrst_meta_r, lrst_r;
	line_code_t lcode_s1_r, lcode_s2_r, lcode_s3_r, lcode_r;

	always_ff @(posedge line_clock) begin
		lrst_meta_r <= reset;
		lrst_r      <= lrst_meta_r;
		lcode_s1_r  <= code_sel;
		lcode_s2_r  <= lcode_s1_r;
		lcode_s3_r  <= lcode_s2_r;
		if (lrst_r)
			lcode_r <= code_hdb3;
		else if (lcode_s2_r == lcode_s3_r)
			lcode_r <= lcode_s3_r;
	end

	symbol_t  dsym_r [DEC_DEPTH];
	symbol_t  dsym_nxt [DEC_DEPTH];
	logic     dbit_r [DEC_DEPTH];
	logic     dbit_nxt [DEC_DEPTH];
	logic     lastpol_r, lastpol_nxt;
	logic     oldpol_r, oldpol_nxt;
	rx_word_t lword_r, lword_nxt;
	logic     ltog_r, ltog_nxt;
	logic     zs_hit;

	always_comb begin
		dsym_nxt[0] = rx_line;
		dbit_nxt[0] = rx_line.pos | rx_line.neg;
		for (int i = 1; i < DEC_DEPTH; i++) begin
			dsym_nxt[i] = dsym_r[i-1];
			dbit_nxt[i] = dbit_r[i-1];
		end
		lastpol_nxt = lastpol_r;
		oldpol_nxt  = oldpol_r;
		if (dsym_r[5].pos | dsym_r[5].neg)
			oldpol_nxt = dsym_r[5].pos;
		if (dbit_nxt[0]) begin
			lastpol_nxt = rx_line.pos;
			if (lcode_r == code_hdb3 && rx_line.pos == lastpol_r) begin
				for (int i = 0; i < 4; i++)
					dbit_nxt[i] = 1'b0;
			end
		end
		zs_hit = (dsym_nxt[5] == '0) && (dsym_nxt[2] == '0)
			&& has_pol(dsym_nxt[4], oldpol_nxt)
			&& has_pol(dsym_nxt[3], ~oldpol_nxt)
			&& has_pol(dsym_nxt[1], ~oldpol_nxt)
			&& has_pol(dsym_nxt[0], oldpol_nxt);
		if (lcode_r == code_b8zs)
			zs_hit = zs_hit && (dsym_nxt[6] == '0) && (dsym_nxt[7] == '0);
		if (lcode_r != code_hdb3 && zs_hit) begin
			for (int i = 0; i < 5; i++)
				dbit_nxt[i] = 1'b0;
		end
		lword_nxt = '{data: dbit_r[DEC_DEPTH-1], mark: dbit_nxt[0]};
		ltog_nxt  = ~ltog_r;
	end

	always_ff @(posedge line_clock) begin
		if (lrst_r) begin
			for (int i = 0; i < DEC_DEPTH; i++) begin
				dsym_r[i] <= '0;
				dbit_r[i] <= 1'b0;
			end
			lastpol_r <= 1'b0;
			oldpol_r  <= 1'b0;
			lword_r   <= '0;
			ltog_r    <= 1'b0;
		end else begin
			dsym_r    <= dsym_nxt;
			dbit_r    <= dbit_nxt;
			lastpol_r <= lastpol_nxt;
			oldpol_r  <= oldpol_nxt;
			lword_r   <= lword_nxt;
			ltog_r    <= ltog_nxt;
		end
	end

	// Word is held a full line bit, far longer than the toggle takes to cross
	logic     tog1_r, tog2_r, tog3_r, seen_r, seen_nxt;
	logic     rx_ev;
	rx_word_t rx_word;
	logic [9:0] idle_r, idle_nxt;
	logic [7:0] zcnt_r, zcnt_nxt;
	logic       lost_r, lost_nxt;
	logic       report_r, report_nxt;

	always_ff @(posedge clock) begin
		tog1_r <= ltog_r;
		tog2_r <= tog1_r;
		tog3_r <= tog2_r;
	end

	always_comb begin
		rx_ev    = (tog2_r == tog3_r) && (tog3_r != seen_r);
		rx_word  = lword_r;
		seen_nxt = rx_ev ? tog3_r : seen_r;
		idle_nxt = rx_ev ? 10'h000 : idle_r;
		if (!rx_ev && idle_r != LINE_IDLE_CYC)
			idle_nxt = idle_r + 10'h001;
		zcnt_nxt = zcnt_r;
		if (rx_ev) begin
			if (rx_word.mark)
				zcnt_nxt = 8'h00;
			else if (zcnt_r != los_zeros)
				zcnt_nxt = zcnt_r + 8'h01;
		end
		// Declared at once, far inside the reaction limit
		lost_nxt   = (idle_nxt == LINE_IDLE_CYC) || (zcnt_nxt == los_zeros);
		report_nxt = lost_nxt & monitored_state;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			seen_r   <= 1'b0;
			idle_r   <= LINE_IDLE_CYC;
			zcnt_r   <= 8'h00;
			lost_r   <= 1'b1;
			report_r <= 1'b0;
		end else begin
			seen_r   <= seen_nxt;
			idle_r   <= idle_nxt;
			zcnt_r   <= zcnt_nxt;
			lost_r   <= lost_nxt;
			report_r <= report_nxt;
		end
	end

	assign signal_lost_defect = report_r;

	// Two-entry output buffer; the line cannot stall, so a full buffer
	// drops the word and flags it
	logic       buf_r [BUF_DEPTH];
	logic       buf_nxt [BUF_DEPTH];
	logic [1:0] cnt_r, cnt_nxt;
	logic       ovr_r, ovr_nxt;
	logic       push, push_bit, pop, buf_ready;
	logic [1:0] wr_at;

	always_comb begin
		pop       = (cnt_r != 2'h0) && out_ready;
		buf_ready = (cnt_r != 2'(BUF_DEPTH)) || pop;
		if (lost_r) begin
			push     = bit_tick;
			push_bit = 1'b1;
		end else begin
			push     = rx_ev;
			push_bit = rx_word.data;
		end
		buf_nxt = buf_r;
		cnt_nxt = cnt_r;
		if (pop) begin
			buf_nxt[0] = buf_r[1];
			cnt_nxt    = cnt_r - 2'h1;
		end
		wr_at   = cnt_nxt;
		ovr_nxt = push && !buf_ready;
		if (push && buf_ready) begin
			buf_nxt[wr_at[0]] = push_bit;
			cnt_nxt           = cnt_nxt + 2'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_r[i] <= 1'b1;
			cnt_r <= 2'h0;
			ovr_r <= 1'b0;
		end else begin
			buf_r <= buf_nxt;
			cnt_r <= cnt_nxt;
			ovr_r <= ovr_nxt;
		end
	end

	assign out_valid  = (cnt_r != 2'h0);
	assign out_data   = buf_r[0];
	assign rx_overrun = ovr_r;
endmodule : pdh_line_codec

/* sim/pdh_line_codec_assertions.sv */
// Assertions on the codec ports, bound into the design.
// Assumes one system clock domain with synchronous reset.
`timescale 1ns/100ps
module pdh_line_codec_assertions (
	input wire logic clock,
	input wire logic reset,
	input wire pdh_codec_pkg::symbol_t tx_line,
	input wire logic tx_clock,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_data,
	input wire logic out_ready,
	input wire logic rx_overrun,
	input wire logic monitored_state,
	input wire logic signal_lost_defect
);
	import pdh_codec_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	a_tx_edge: assert property (
		!$stable(tx_line) |-> $rose(tx_clock)) else $error("tx off edge");
	a_tx_legal: assert property (
		!(tx_line.pos && tx_line.neg)) else $error("tx both marks");
	a_tick_gap: assert property (
		in_ready |=> !in_ready [*8]) else $error("ticks too close");
	a_tick_due: assert property (
		in_ready |-> ##[1:130] in_ready) else $error("tick late");
	a_report_mon: assert property (
		!monitored_state |=> !signal_lost_defect) else $error("unmon report");
	a_out_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output not held");
	a_ovr_full: assert property (
		rx_overrun |-> $past(out_valid)) else $error("overrun not full");
	a_alarm_fill: assert property (
		signal_lost_defect && out_ready |-> ##[0:130] out_valid)
		else $error("alarm ones missing");
	c_taken: cover property (in_ready);
	c_overrun: cover property (rx_overrun);
	c_defect: cover property ($rose(signal_lost_defect));
endmodule : pdh_line_codec_assertions
bind pdh_line_codec pdh_line_codec_assertions chk_i (.clock, .reset,
	.tx_line, .tx_clock, .in_ready, .out_valid, .out_data, .out_ready,
	.rx_overrun, .monitored_state, .signal_lost_defect);

/* sim/line_partner.sv */
// Line transceiver model: recovered clock and sliced AMI marks.
// Assumes the bench gates it with run and picks the bit pattern.
`timescale 1ns/100ps
module line_partner (
	output logic line_clock,
	output pdh_codec_pkg::symbol_t rx_line,
	input wire logic run,
	input wire logic [15:0] pattern
);
	import pdh_codec_pkg::*;
	logic neg_r = 1'b1;
	int k = 0;
	// Clock stands still between bursts, as a silent line gives none
	initial begin
		line_clock = 1'b0;
		rx_line = '0;
		#1.3;
		forever #24 line_clock = run ? ~line_clock : 1'b0;
	end
	// Plain AMI without long zero runs is legal under every code
	always @(negedge line_clock) begin
		rx_line <= (run && pattern[k]) ? (neg_r ? 2'h2 : 2'h1) : 2'h0;
		if (pattern[k])
			neg_r <= ~neg_r;
		k <= (k + 1) % 16;
	end
	always @(negedge run) rx_line <= '0;
endmodule : line_partner

/* sim/pdh_line_codec_tb.sv */
// Bench for the line codec: transmit codes, receive path, signal loss.
// Assumes line_partner stands in for the line transceiver.
`timescale 1ns/100ps
module pdh_line_codec_tb;
	import pdh_codec_pkg::*;
	localparam logic [1:0] P = 2'h2, M = 2'h1, Z = 2'h0;
	logic clock = 1'b0, reset = 1'b1, in_valid = 1'b1, in_data = 1'b1;
	logic out_ready = 1'b1, rate_6m = 1'b0, coax_pair = 1'b0, run = 1'b1;
	logic monitored_state = 1'b1, line_clock, rx_overrun, tx_clock;
	logic in_ready, out_valid, out_data, signal_lost_defect;
	logic [15:0] pattern = 16'hB6DB;
	symbol_t rx_line, tx_line;
	int errors = 0, n_tests = 0;
	always #2 clock = ~clock;
	pdh_line_codec DUT (.clock, .reset, .line_clock, .rx_line, .rx_overrun,
		.tx_line, .tx_clock, .in_valid, .in_data, .in_ready, .out_valid,
		.out_data, .out_ready, .rate_6m, .coax_pair, .monitored_state,
		.signal_lost_defect);
	line_partner line_i (.line_clock, .rx_line, .run, .pattern);
	task automatic complete_run;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic pop(output logic b);
		int k = 0;
		do @(posedge clock); while (out_valid !== 1'b1 && ++k < 400);
		b = out_data;
	endtask : pop
	// Held past two line clocks, since the line side resets through syncs
	task automatic rst(input logic r6, cx, d, m);
		@(negedge clock);
		reset = 1'b1;
		{rate_6m, coax_pair, in_data, monitored_state} = {r6, cx, d, m};
		{pattern, run} = {16'hB6DB, 1'b1};
		repeat (30) @(negedge clock);
		reset = 1'b0;
	endtask : rst
	task automatic t_tx(input logic r6, cx, input logic [9:0] b,
		input logic [19:0] e);
		symbol_t q[$];
		int k;
		rst(r6, cx, b[0], 1'b1);
		for (int i = 1; i < 22; i++) begin
			k = 0;
			do @(posedge clock); while (in_ready !== 1'b1 && ++k < 200);
			@(negedge clock);
			in_data = (i < 10) ? b[i] : 1'b1;
			repeat (10) @(negedge clock);
			q.push_back(tx_line);
		end
		k = 0;
		while (k < 10 && q[k] === 2'h0) k++;
		for (int i = 0; i < 10; i++)
			chk(q[k + i] === e[19 - 2 * i -: 2], "symbol");
	endtask : t_tx
	task automatic t_rate;
		realtime t0;
		rst(1'b0, 1'b0, 1'b1, 1'b1);
		@(posedge tx_clock);
		t0 = $realtime;
		repeat (256) @(posedge tx_clock);
		chk(($realtime - t0 - 125000.0) ** 2 < 39.0, "rate");
		// A starved source must still put marks on the line, never a zero run
		@(negedge clock);
		{in_valid, in_data} = 2'b00;
		repeat (8) @(posedge tx_clock);
		for (int i = 0; i < 8; i++) begin
			@(posedge tx_clock);
			repeat (3) @(negedge clock);
			chk(tx_line.pos ^ tx_line.neg, "idle ones");
		end
		@(negedge clock);
		in_valid = 1'b1;
	endtask : t_rate
	task automatic t_rx(input logic r6, cx);
		logic [63:0] v;
		int k = 0;
		rst(r6, cx, 1'b1, 1'b1);
		repeat (40) pop(v[0]);
		for (int i = 0; i < 64; i++)
			pop(v[i]);
		chk(v[47:0] === v[63:16] && $countones(v) == 44, "rx data");
		@(negedge clock);
		out_ready = 1'b0;
		do @(posedge clock); while (rx_overrun !== 1'b1 && ++k < 300);
		chk(k < 300 && out_valid === 1'b1, "stall");
		@(negedge clock);
		out_ready = 1'b1;
	endtask : t_rx
	task automatic t_los(input logic r6, mon);
		logic b;
		int k = 0;
		rst(r6, 1'b0, 1'b1, mon);
		repeat (20) pop(b);
		@(negedge clock);
		if (r6) pattern = 16'h0000; else run = 1'b0;
		do @(posedge clock);
		while (++k < 4000 && (signal_lost_defect !== 1'b1 || !mon));
		chk(signal_lost_defect === mon, "defect");
		repeat (10) pop(b);
		for (int i = 0; i < 8; i++) begin
			pop(b);
			chk(b === 1'b1, "alarm ones");
		end
		@(negedge clock);
		{pattern, run} = {16'hB6DB, 1'b1};
		k = 0;
		do pop(b); while (b !== 1'b0 && ++k < 100);
		chk(k < 100 && signal_lost_defect === 1'b0, "resume");
	endtask : t_los
	initial begin
		t_tx(1'b0, 1'b0, 10'h201, {P,Z,Z,Z,P,M,Z,Z,M,P});
		t_tx(1'b1, 1'b0, 10'h381, {P,Z,P,M,Z,M,P,M,P,M});
		t_tx(1'b1, 1'b1, 10'h201, {P,Z,Z,Z,P,M,Z,M,P,M});
		t_rate;
		t_rx(1'b0, 1'b0);
		t_rx(1'b1, 1'b0);
		t_rx(1'b1, 1'b1);
		t_los(1'b0, 1'b1);
		t_los(1'b1, 1'b1);
		t_los(1'b0, 1'b0);
		complete_run;
	end
	// Whole sequence needs about 220 us
	initial begin
		#400000;
		errors++;
		complete_run;
	end
endmodule : pdh_line_codec_tb
